/* File: hw/usart_status_params.svh */
// offsets, field positions, reset values and masks of the status/irq block
`ifndef USART_STATUS_PARAMS_SVH
`define USART_STATUS_PARAMS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_STATUS 5'h00
`define OFF_DATA 5'h04
`define OFF_BAUD 5'h08
`define OFF_CTRL1 5'h0C
`define OFF_CTRL2 5'h10
`define OFF_CTRL3 5'h14
`define OFF_GUARD 5'h18
// ----------------------------------------
// status bits
// ----------------------------------------
`define ST_CTS 9
`define ST_LIN 8
`define ST_TXE 7
`define ST_TXC 6
`define ST_RXNE 5
`define ST_IDLE 4
`define ST_ORE 3
`define ST_NE 2
`define ST_FE 1
`define ST_PE 0
`define STATUS_RESET 10'h0C0
// ----------------------------------------
// control bits
// ----------------------------------------
`define C1_PARITY_IRQ_EN 8
`define C1_TXEIEN 7
`define C1_TX_DONE_IRQ_EN 6
`define C1_RXIEN 5
`define C1_IDLE_IRQ_EN 4
`define C2_LIN_MODE_EN 14
`define C2_LINIEN 6
`define C3_CTS_CHANGE_IRQ_EN 10
`define C3_CTS_MONITOR_EN 9
`define C3_DMARX 6
`define C3_MULTI_ERR_IRQ_EN 0
// ----------------------------------------
// writable masks, full and reduced instances
// ----------------------------------------
`define C1_MASK 16'h3FFF
`define C2_MASK_FULL 16'h7F6F
`define C2_MASK_RED 16'h706F
`define C3_MASK_FULL 16'h07FF
`define C3_MASK_RED 16'h00CF
`define CTRL_RESET 16'h0000
`endif

/* File: hw/usart_status_pkg.sv */
// types of the status/irq block
package usart_status_pkg;
	typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;
	typedef logic [15:0] ctrl_word_t;
endpackage

/* File: hw/usart_status_irq.sv */
// status flags, interrupt request and register file of the serial transceiver
//
// Functional notes
// - irq is OR of enabled events
// - single interrupt line per instance
// - tx empty with its enable raises irq
// - rx not empty with rx enable raises irq
// - overrun, idle, parity, break raise irq
// - error irq only while dma receive on
// - reduced instances omit flow, clock, smartcard
// - all instances keep remaining modes
// - status resets to tx empty, tx done
// - cts change sets bit 9, write zero clears
// - cts flag inert on reduced instances
// - lin break sets bit 8, write zero clears
// - tx empty set at reset, on shift load
// - data write clears tx empty
// - tx done set on frame end with empty
// - rx load sets, zero write or read clears
// - idle, overrun, noise cleared by status-data reads
`timescale 1ns/1ps
`include "usart_status_params.svh"

module usart_status_irq #(
	parameter bit FULL_INSTANCE = 1'b1,
	parameter int DATA_W = 9
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic clear_to_send_in_n,
	input wire logic tx_shift_load,
	input wire logic tx_frame_end,
	input wire logic rx_load,
	input wire logic [DATA_W-1:0] rx_word,
	input wire logic idle_event,
	input wire logic parity_event,
	input wire logic noise_event,
	input wire logic framing_event,
	input wire logic break_event,
	output logic [DATA_W-1:0] tx_word,
	output logic tx_word_write,
	output logic rx_word_read,
	output logic [15:0] baud_divider,
	output logic [15:0] control_one,
	output logic [15:0] control_two,
	output logic [15:0] control_three,
	output logic [15:0] guard_time_prescaler,
	output logic irq
);
	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	usart_status_pkg::bus_state_t state_r;
	usart_status_pkg::bus_state_t state_nxt;
	logic wait_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	wire req = avs_read | avs_write;
	wire acc = req & ~wait_r;
	wire wr = acc & avs_write;
	wire rd = acc & avs_read;
	wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire [31:0] wd_m = avs_writedata & be_mask;
	wire sel_sts = avs_address == `OFF_STATUS;
	wire sel_dat = avs_address == `OFF_DATA;
	wire sel_brd = avs_address == `OFF_BAUD;
	wire sel_c1 = avs_address == `OFF_CTRL1;
	wire sel_c2 = avs_address == `OFF_CTRL2;
	wire sel_c3 = avs_address == `OFF_CTRL3;
	wire sel_gtp = avs_address == `OFF_GUARD;
	wire wr_sts = wr & sel_sts;
	wire wr_dat = wr & sel_dat & avs_byteenable[0];
	wire rd_sts = rd & sel_sts;
	wire rd_dat = rd & sel_dat;

	// ----------------------------------------
	// instance trimming
	// ----------------------------------------
	wire [15:0] c2_mask = FULL_INSTANCE ? `C2_MASK_FULL : `C2_MASK_RED;
	wire [15:0] c3_mask = FULL_INSTANCE ? `C3_MASK_FULL : `C3_MASK_RED;

	// ----------------------------------------
	// pin synchroniser and change detect
	// ----------------------------------------
	logic cts_s1_r;
	logic cts_s2_r;
	logic cts_s3_r;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cts_s1_r <= 1'b1;
			cts_s2_r <= 1'b1;
			cts_s3_r <= 1'b1;
		end
		else if (clk_en)
		begin
			cts_s1_r <= clear_to_send_in_n;
			cts_s2_r <= cts_s1_r;
			cts_s3_r <= cts_s2_r;
		end
	end
	wire cts_mon = FULL_INSTANCE & control_three[`C3_CTS_MONITOR_EN];
	wire cts_set = cts_mon & (cts_s2_r ^ cts_s3_r);

	// ----------------------------------------
	// status flags
	// ----------------------------------------
	logic [9:0] sts_r;
	logic [9:0] sts_nxt;
	logic armed_r;
	wire seq_clr = rd_dat & armed_r;
	// write zero clears, write one keeps
	wire [9:0] wz = wr_sts & avs_byteenable[0] ? ~wd_m[9:0] : 10'h000;
	wire wz_hi = wr_sts & avs_byteenable[1];
	wire clr_cts = wz_hi & ~wd_m[`ST_CTS];
	wire clr_lin = wz_hi & ~wd_m[`ST_LIN];
	wire clr_txc = wz[`ST_TXC];
	wire clr_rxne = wz[`ST_RXNE] | rd_dat;
	wire set_lin = break_event & control_two[`C2_LIN_MODE_EN];
	wire set_txc = tx_frame_end & sts_r[`ST_TXE];
	wire set_ore = rx_load & sts_r[`ST_RXNE];
	always_comb
	begin
		sts_nxt = sts_r;
		// set wins over clear in every flag
		sts_nxt[`ST_CTS] = cts_set | (sts_r[`ST_CTS] & ~clr_cts);
		sts_nxt[`ST_LIN] = set_lin | (sts_r[`ST_LIN] & ~clr_lin);
		sts_nxt[`ST_TXE] = tx_shift_load | (sts_r[`ST_TXE] & ~wr_dat);
		sts_nxt[`ST_TXC] = set_txc | (sts_r[`ST_TXC] & ~clr_txc);
		sts_nxt[`ST_RXNE] = rx_load | (sts_r[`ST_RXNE] & ~clr_rxne);
		sts_nxt[`ST_IDLE] = idle_event | (sts_r[`ST_IDLE] & ~seq_clr);
		sts_nxt[`ST_ORE] = set_ore | (sts_r[`ST_ORE] & ~seq_clr);
		sts_nxt[`ST_NE] = noise_event | (sts_r[`ST_NE] & ~seq_clr);
		sts_nxt[`ST_FE] = framing_event | (sts_r[`ST_FE] & ~seq_clr);
		sts_nxt[`ST_PE] = parity_event | (sts_r[`ST_PE] & ~seq_clr);
	end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			sts_r <= `STATUS_RESET;
		else if (clk_en)
			sts_r <= sts_nxt;
	end
	// status read arms the data-read clear, any other access disarms
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			armed_r <= 1'b0;
		else if (clk_en && acc)
			armed_r <= rd_sts;
	end

	// ----------------------------------------
	// control, baud, guard and data registers
	// ----------------------------------------
	logic [DATA_W-1:0] rxd_r;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			baud_divider <= `CTRL_RESET;
			control_one <= `CTRL_RESET;
			control_two <= `CTRL_RESET;
			control_three <= `CTRL_RESET;
			guard_time_prescaler <= `CTRL_RESET;
		end
		else if (clk_en && wr)
		begin
			if (sel_brd)
				baud_divider <= (baud_divider & ~be_mask[15:0]) | wd_m[15:0];
			if (sel_c1)
				control_one <= ((control_one & ~be_mask[15:0]) | wd_m[15:0]) & `C1_MASK;
			if (sel_c2)
				control_two <= ((control_two & ~be_mask[15:0]) | wd_m[15:0]) & c2_mask;
			if (sel_c3)
				control_three <= ((control_three & ~be_mask[15:0]) | wd_m[15:0]) & c3_mask;
			if (sel_gtp)
				guard_time_prescaler <= (guard_time_prescaler & ~be_mask[15:0]) | wd_m[15:0];
		end
	end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tx_word <= '0;
			tx_word_write <= 1'b0;
			rx_word_read <= 1'b0;
			rxd_r <= '0;
		end
		else if (clk_en)
		begin
			tx_word_write <= wr_dat;
			rx_word_read <= rd_dat;
			if (wr_dat)
				tx_word <= avs_writedata[DATA_W-1:0];
			if (rx_load)
				rxd_r <= rx_word;
		end
	end

	// ----------------------------------------
	// interrupt combine
	// ----------------------------------------
	wire ev_txe = sts_r[`ST_TXE] & control_one[`C1_TXEIEN];
	wire ev_cts = sts_r[`ST_CTS] & control_three[`C3_CTS_CHANGE_IRQ_EN];
	wire ev_txc = sts_r[`ST_TXC] & control_one[`C1_TX_DONE_IRQ_EN];
	wire ev_rx = (sts_r[`ST_RXNE] | sts_r[`ST_ORE]) & control_one[`C1_RXIEN];
	wire ev_idle = sts_r[`ST_IDLE] & control_one[`C1_IDLE_IRQ_EN];
	wire ev_pe = sts_r[`ST_PE] & control_one[`C1_PARITY_IRQ_EN];
	wire ev_lin = sts_r[`ST_LIN] & control_two[`C2_LINIEN];
	wire err_any = sts_r[`ST_NE] | sts_r[`ST_ORE] | sts_r[`ST_FE];
	wire ev_err = err_any & control_three[`C3_MULTI_ERR_IRQ_EN] & control_three[`C3_DMARX];
	wire irq_nxt = ev_txe | ev_cts | ev_txc | ev_rx | ev_idle | ev_pe | ev_lin | ev_err;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			irq <= 1'b0;
		else if (clk_en)
			irq <= irq_nxt;
	end

	// ----------------------------------------
	// read mux and bus handshake
	// ----------------------------------------
	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		if (sel_sts)
			rdata_nxt = {22'h000000, sts_r};
		if (sel_dat)
			rdata_nxt = {{(32-DATA_W){1'b0}}, rxd_r};
		if (sel_brd)
			rdata_nxt = {16'h0000, baud_divider};
		if (sel_c1)
			rdata_nxt = {16'h0000, control_one};
		if (sel_c2)
			rdata_nxt = {16'h0000, control_two};
		if (sel_c3)
			rdata_nxt = {16'h0000, control_three};
		if (sel_gtp)
			rdata_nxt = {16'h0000, guard_time_prescaler};
	end
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			usart_status_pkg::BUS_IDLE:
				if (req)
					state_nxt = usart_status_pkg::BUS_ANSWER;
			usart_status_pkg::BUS_ANSWER:
				state_nxt = usart_status_pkg::BUS_IDLE;
		endcase
	end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= usart_status_pkg::BUS_IDLE;
			wait_r <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			state_r <= state_nxt;
			wait_r <= state_nxt != usart_status_pkg::BUS_ANSWER;
			if (state_r == usart_status_pkg::BUS_IDLE && avs_read)
				rdata_r <= rdata_nxt;
		end
	end
	assign avs_waitrequest = wait_r;
	assign avs_readdata = rdata_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_data_write;
		clk_en && wr_dat && !tx_shift_load;
	endsequence
	sequence s_status_then_data;
		clk_en && rd_sts ##[1:8] clk_en && rd_dat && armed_r;
	endsequence
	chk_irq_or_level: assert property (@(posedge clk) disable iff (rst)
		clk_en |=> irq == $past(irq_nxt)) else $error("irq not OR of enabled flags");
	chk_irq_holds: assert property (@(posedge clk) disable iff (rst)
		clk_en && irq_nxt && $past(clk_en) && $past(irq_nxt) |-> irq) else $error("irq dropped while pending");
	chk_txe_irq: assert property (@(posedge clk) disable iff (rst)
		clk_en && sts_r[`ST_TXE] && control_one[`C1_TXEIEN] |=> irq) else $error("tx empty irq missing");
	chk_rx_irq: assert property (@(posedge clk) disable iff (rst)
		clk_en && sts_r[`ST_RXNE] && control_one[`C1_RXIEN] |=> irq) else $error("rx irq missing");
	chk_err_gate: assert property (@(posedge clk) disable iff (rst)
		clk_en && control_three[`C3_MULTI_ERR_IRQ_EN] && control_three[`C3_DMARX] && sts_r[`ST_NE] |=> irq)
		else $error("error irq missing with dma receive");
	chk_txe_clear: assert property (@(posedge clk) disable iff (rst)
		s_data_write |=> !sts_r[`ST_TXE] ##1 tx_word_write == 1'b0) else $error("tx empty not cleared");
	chk_txe_set: assert property (@(posedge clk) disable iff (rst)
		clk_en && tx_shift_load |=> sts_r[`ST_TXE]) else $error("tx empty not set");
	chk_txc_set: assert property (@(posedge clk) disable iff (rst)
		clk_en && tx_frame_end && sts_r[`ST_TXE] |=> sts_r[`ST_TXC]) else $error("tx done not set");
	chk_seq_clear: assert property (@(posedge clk) disable iff (rst)
		s_status_then_data ##0 !idle_event && !noise_event |=> !sts_r[`ST_IDLE] && !sts_r[`ST_NE])
		else $error("status-data read did not clear");
	chk_write_one: assert property (@(posedge clk) disable iff (rst)
		clk_en && wr_sts && avs_byteenable[0] && wd_m[`ST_TXC] && sts_r[`ST_TXC] |=> sts_r[`ST_TXC])
		else $error("write one cleared flag");
	chk_cts_reduced: assert property (@(posedge clk) disable iff (rst)
		!FULL_INSTANCE |-> !sts_r[`ST_CTS]) else $error("cts flag on reduced instance");
	chk_lin_set: assert property (@(posedge clk) disable iff (rst)
		clk_en && break_event && control_two[`C2_LIN_MODE_EN] |=> sts_r[`ST_LIN]) else $error("lin break lost");
	chk_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
		!avs_waitrequest && avs_read && sel_sts |-> avs_readdata[31:10] == 22'h000000)
		else $error("reserved status bits nonzero");
	chk_ore_set: assert property (@(posedge clk) disable iff (rst)
		clk_en && rx_load && sts_r[`ST_RXNE] |=> sts_r[`ST_ORE] && sts_r[`ST_RXNE]) else $error("overrun lost");
	chk_answer_one: assert property (@(posedge clk) disable iff (rst)
		!avs_waitrequest && clk_en |=> avs_waitrequest) else $error("answer longer than one cycle");

	// ----------------------------------------
	// checks, flag set and clear, data strobes, reduced control masks
	// ----------------------------------------
	chk_rxne_set: assert property (@(posedge clk) disable iff (rst)
		clk_en && rx_load |=> sts_r[`ST_RXNE]) else $error("rx not empty not set");
	chk_rxne_read: assert property (@(posedge clk) disable iff (rst)
		clk_en && rd_dat && !rx_load |=> !sts_r[`ST_RXNE]) else $error("data read did not clear rx flag");
	chk_txc_clear: assert property (@(posedge clk) disable iff (rst)
		clk_en && wr_sts && avs_byteenable[0] && !avs_writedata[`ST_TXC] && !(tx_frame_end && sts_r[`ST_TXE])
		|=> !sts_r[`ST_TXC]) else $error("tx done not cleared");
	chk_cts_set: assert property (@(posedge clk) disable iff (rst)
		clk_en && FULL_INSTANCE && control_three[`C3_CTS_MONITOR_EN] && cts_s2_r != cts_s3_r
		|=> sts_r[`ST_CTS]) else $error("cts change lost");
	chk_cts_clear: assert property (@(posedge clk) disable iff (rst)
		clk_en && wr_sts && avs_byteenable[1] && !avs_writedata[`ST_CTS] && !cts_set
		|=> !sts_r[`ST_CTS]) else $error("cts flag not cleared");
	chk_lin_clear: assert property (@(posedge clk) disable iff (rst)
		clk_en && wr_sts && avs_byteenable[1] && !avs_writedata[`ST_LIN] && !set_lin
		|=> !sts_r[`ST_LIN]) else $error("lin flag not cleared");
	chk_data_load: assert property (@(posedge clk) disable iff (rst)
		clk_en && wr_dat |=> tx_word_write && tx_word == $past(avs_writedata[DATA_W-1:0])) else $error("tx word lost");
	chk_read_pulse: assert property (@(posedge clk) disable iff (rst)
		clk_en && rd_dat |=> rx_word_read) else $error("data read pulse missing");
	chk_reduced_ctrl: assert property (@(posedge clk) disable iff (rst)
		!FULL_INSTANCE |-> (control_two & ~`C2_MASK_RED) == 16'h0000 && (control_three & ~`C3_MASK_RED) == 16'h0000)
		else $error("reduced instance holds absent mode bits");

	// ----------------------------------------
	// checks, interrupt paths
	// ----------------------------------------
	sequence s_load_enabled;
		clk_en && tx_shift_load && control_one[`C1_TXEIEN] ##1 clk_en && control_one[`C1_TXEIEN];
	endsequence
	chk_load_irq: assert property (@(posedge clk) disable iff (rst)
		s_load_enabled |-> sts_r[`ST_TXE] ##1 irq) else $error("tx empty irq after load missing");
	chk_idle_irq: assert property (@(posedge clk) disable iff (rst)
		clk_en && sts_r[`ST_IDLE] && control_one[`C1_IDLE_IRQ_EN] |=> irq) else $error("idle irq missing");
	chk_pe_irq: assert property (@(posedge clk) disable iff (rst)
		clk_en && sts_r[`ST_PE] && control_one[`C1_PARITY_IRQ_EN] |=> irq) else $error("parity irq missing");
	chk_lin_irq: assert property (@(posedge clk) disable iff (rst)
		clk_en && sts_r[`ST_LIN] && control_two[`C2_LINIEN] |=> irq) else $error("lin break irq missing");
	chk_cts_irq: assert property (@(posedge clk) disable iff (rst)
		clk_en && sts_r[`ST_CTS] && control_three[`C3_CTS_CHANGE_IRQ_EN] |=> irq) else $error("cts irq missing");
	chk_txc_irq: assert property (@(posedge clk) disable iff (rst)
		clk_en && sts_r[`ST_TXC] && control_one[`C1_TX_DONE_IRQ_EN] |=> irq) else $error("tx done irq missing");
endmodule

/* File: sim/remote_xcvr.sv */
// far-side model: transmit shifter timing and receive buffer loads
`timescale 1ns/1ps
module remote_xcvr #(
	parameter int LOAD_DLY = 20,
	parameter int FRAME_DLY = 20
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic tx_word_write,
	input wire logic rx_go,
	input wire logic [8:0] rx_data,
	output logic tx_shift_load,
	output logic tx_frame_end,
	output logic rx_load,
	output logic [8:0] rx_word
);
	int cnt_r;
	// ----
	// word taken into the shifter, then frame shifted out
	// ----
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_r <= 0;
			tx_shift_load <= 1'b0;
			tx_frame_end <= 1'b0;
			rx_load <= 1'b0;
			rx_word <= 9'h000;
		end
		else
		begin
			if (tx_word_write)
				cnt_r <= 1;
			else if (cnt_r == LOAD_DLY + FRAME_DLY)
				cnt_r <= 0;
			else if (cnt_r != 0)
				cnt_r <= cnt_r + 1;
			tx_shift_load <= (cnt_r == LOAD_DLY);
			tx_frame_end <= (cnt_r == LOAD_DLY + FRAME_DLY);
			rx_load <= rx_go;
			// word not valid outside a load: show the inverse
			rx_word <= rx_go ? rx_data : ~rx_word;
		end
	end
endmodule

/* File: sim/testbench.sv */
// self-checking bench of the status and interrupt block
`timescale 1ns/1ps
`include "usart_status_params.svh"
module testbench;
	typedef struct {logic [4:0] a; logic [31:0] v; logic [5:0] m; logic q; logic [31:0] s;} row_t;
	logic clk, rst, rd, wr, sel, cts_n, irq, wq1, wq2, tx_wr, tx_ld, tx_end, rx_ld, rx_rd;
	logic [4:0] addr;
	logic [31:0] wdata, rq1, rq2, q;
	logic [5:0] ev;
	logic [8:0] rx_data, rx_w, tx_w;
	int bad_count, compares;
	row_t rows [11] = '{
		'{`OFF_CTRL1, 32'h0100, 6'h02, 1'b1, 32'h0C1}, '{`OFF_CTRL1, 32'h0010, 6'h01, 1'b1, 32'h0D0},
		'{`OFF_CTRL1, 32'h0020, 6'h20, 1'b1, 32'h0E0}, '{`OFF_CTRL2, 32'h4040, 6'h10, 1'b1, 32'h1C0},
		'{`OFF_CTRL2, 32'h0040, 6'h10, 1'b0, 32'h0C0}, '{`OFF_CTRL3, 32'h0041, 6'h04, 1'b1, 32'h0C4},
		'{`OFF_CTRL3, 32'h0001, 6'h04, 1'b0, 32'h0C4}, '{`OFF_CTRL3, 32'h0041, 6'h08, 1'b1, 32'h0C2},
		'{`OFF_CTRL1, 32'h0100, 6'h04, 1'b0, 32'h0C4}, '{`OFF_CTRL1, 32'h0080, 6'h00, 1'b1, 32'h0C0},
		'{`OFF_CTRL1, 32'h0040, 6'h00, 1'b1, 32'h0C0}};
	// ----
	// design, reduced instance and far side
	// ----
	usart_status_irq dut (.clk(clk), .rst(rst), .clk_en(1'b1), .avs_address(addr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rq1), .avs_waitrequest(wq1),
		.clear_to_send_in_n(cts_n), .tx_shift_load(tx_ld), .tx_frame_end(tx_end), .rx_load(rx_ld), .rx_word(rx_w),
		.idle_event(ev[0]), .parity_event(ev[1]), .noise_event(ev[2]), .framing_event(ev[3]), .break_event(ev[4]),
		.tx_word(tx_w), .tx_word_write(tx_wr), .rx_word_read(rx_rd), .baud_divider(), .control_one(), .control_two(),
		.control_three(), .guard_time_prescaler(), .irq(irq));
	usart_status_irq #(.FULL_INSTANCE(1'b0)) dut_red (.clk(clk), .rst(rst), .clk_en(1'b1), .avs_address(addr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rq2),
		.avs_waitrequest(wq2), .clear_to_send_in_n(cts_n), .tx_shift_load(tx_ld), .tx_frame_end(tx_end),
		.rx_load(rx_ld), .rx_word(rx_w), .idle_event(ev[0]), .parity_event(ev[1]), .noise_event(ev[2]),
		.framing_event(ev[3]), .break_event(ev[4]), .tx_word(), .tx_word_write(), .rx_word_read(), .baud_divider(),
		.control_one(), .control_two(), .control_three(), .guard_time_prescaler(), .irq());
	remote_xcvr far (.clk(clk), .rst(rst), .tx_word_write(tx_wr), .rx_go(ev[5]), .rx_data(rx_data),
		.tx_shift_load(tx_ld), .tx_frame_end(tx_end), .rx_load(rx_ld), .rx_word(rx_w));
	// ----
	// tasks
	// ----
	task automatic results();
		if (bad_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		do
		begin
			@(posedge clk);
		end
		while ((sel ? wq2 : wq1) !== 1'b0);
		q = sel ? rq2 : rq1;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	task automatic pulse(input logic [5:0] m, input logic [8:0] d);
		@(posedge clk);
		ev <= m;
		rx_data <= d;
		@(posedge clk);
		ev <= 6'h00;
	endtask
	task automatic reset_dut();
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		#(4 * 30000);
		bad_count++;
		results();
	end
	initial
	begin
		{rst, rd, wr, sel} = 4'h0;
		ev = 6'h00;
		addr = 5'h00;
		wdata = 32'h0000_0000;
		rx_data = 9'h000;
		bad_count = 0;
		compares = 0;
		cts_n = 1'b1;
		reset_dut();
		rdc(`OFF_STATUS, 32'h0C0);
		rdc(`OFF_CTRL1, 32'h0);
		foreach (rows[i])
		begin
			reset_dut();
			bus(1'b1, rows[i].a, rows[i].v);
			pulse(rows[i].m, 9'h033);
			rdc(`OFF_STATUS, rows[i].s);
			chk({31'h0, irq}, {31'h0, rows[i].q});
		end
		reset_dut();
		bus(1'b1, `OFF_CTRL1, 32'h0080);
		bus(1'b1, `OFF_DATA, 32'h1A5);
		rdc(`OFF_STATUS, 32'h040);
		chk({23'h0, tx_w}, 32'h1A5);
		bus(1'b1, `OFF_STATUS, 32'h300);
		rdc(`OFF_STATUS, 32'h000);
		repeat (60) @(posedge clk);
		rdc(`OFF_STATUS, 32'h0C0);
		chk({31'h0, irq}, 32'h1);
		reset_dut();
		bus(1'b1, `OFF_CTRL1, 32'h0020);
		pulse(6'h20, 9'h155);
		pulse(6'h24, 9'h0AA);
		rdc(`OFF_STATUS, 32'h0EC);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, `OFF_CTRL1, 32'h0020);
		rdc(`OFF_DATA, 32'h0AA);
		@(negedge clk);
		chk({31'h0, rx_rd}, 32'h1);
		rdc(`OFF_STATUS, 32'h0CC);
		chk({31'h0, irq}, 32'h1);
		rdc(`OFF_DATA, 32'h0AA);
		rdc(`OFF_STATUS, 32'h0C0);
		chk({31'h0, irq}, 32'h0);
		reset_dut();
		bus(1'b1, `OFF_CTRL3, 32'h0600);
		cts_n <= 1'b0;
		repeat (8) @(posedge clk);
		rdc(`OFF_STATUS, 32'h2C0);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, `OFF_STATUS, 32'h3C0);
		rdc(`OFF_STATUS, 32'h2C0);
		bus(1'b1, `OFF_STATUS, 32'h0C0);
		rdc(`OFF_STATUS, 32'h0C0);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, 5'h1C, 32'hFFFF);
		rdc(5'h1C, 32'h0);
		bus(1'b1, `OFF_BAUD, 32'h0000_1234);
		rdc(`OFF_BAUD, 32'h0000_1234);
		bus(1'b1, `OFF_GUARD, 32'h0000_AB12);
		rdc(`OFF_GUARD, 32'h0000_AB12);
		bus(1'b1, `OFF_CTRL2, 32'h7F6F);
		rdc(`OFF_CTRL2, 32'h7F6F);
		sel <= 1'b1;
		rdc(`OFF_CTRL2, 32'h706F);
		bus(1'b1, `OFF_CTRL3, 32'h07FF);
		rdc(`OFF_CTRL3, 32'h00CF);
		cts_n <= 1'b1;
		repeat (8) @(posedge clk);
		rdc(`OFF_STATUS, 32'h0C0);
		results();
	end
endmodule
